// ===== hdl/urx_core.sv
// Purpose: UART receiver with sticky receive error status and error clear.
// Assumes: 16x oversampling; divisor sets core_clk cycles per tick minus one.
// Notes:   Status and clear share one address: reads see status, writes clear.
//
// Behaviour
// - Full FIFO on new character sets overrun.
// - Overrun keeps FIFO contents, drops new word.
// - Line low a whole character sets break.
// - Break pushes exactly one zero character.
// - After break, wait for high then start.
// - Break and framing travel with their character.
// - Parity mismatch per line control sets parity.
// - Zero stop bit sets framing error, except on break.
// - Any clear write clears all four flags.
// - Status read-only, upper bits read zero.
// - Status collects flags of every entry read from data.
// - Overrun shows at once in status.
// - Reset clears all four flags.
`timescale 1ns/1ps
module urx_core
#(
   parameter int FIFO_DEPTH = 16
)
(
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial receive pin
   input  wire logic        rx_pin
);
   localparam int EW = 11;
   logic                rx_s;
   urx_pkg::urx_state_t state;
   urx_pkg::urx_state_t next_state;
   logic [15:0]         tick_cnt;
   logic [15:0]         next_tick_cnt;
   logic [3:0]          os_cnt;
   logic [3:0]          next_os_cnt;
   logic [2:0]          bit_idx;
   logic [2:0]          next_bit_idx;
   logic [7:0]          shift;
   logic [7:0]          next_shift;
   logic                par_bit;
   logic                next_par_bit;
   logic                all_low;
   logic                next_all_low;
   logic                tick;
   logic                sample;
   logic                rx_push;
   logic [EW-1:0]       rx_entry;
   logic                par_exp;
   logic [2:0]          last_idx;
   logic [7:0]          lcr;
   logic [7:0]          next_lcr;
   logic [15:0]         divisor;
   logic [15:0]         next_divisor;
   logic [3:0]          flags;
   logic [3:0]          next_flags;
   logic [31:0]         next_prdata;
   logic                next_pslverr;
   logic                pop_pend;
   logic                next_pop_pend;
   logic                fifo_pop;
   logic [EW-1:0]       fifo_head;
   logic                fifo_empty;
   logic                fifo_full;
   logic                setup;
   logic                access;
   logic                clear_wr;
   urx_sync #(.WIDTH(1)) u_sync
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (rx_pin),
      .sync_out (rx_s)
   );
   urx_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .fifo_en   (lcr[urx_pkg::LCR_FIFO_EN]),
      .push      (rx_push),
      .push_data (rx_entry),
      .pop       (fifo_pop),
      .head      (fifo_head),
      .empty     (fifo_empty),
      .full      (fifo_full)
   );
   // Freezing with clk_en also stalls the bus rather than losing a transfer
   assign pready   = clk_en;
   assign setup    = psel && !penable;
   assign access   = psel && penable && pready;
   assign clear_wr = access && pwrite && (paddr == urx_pkg::ADDR_STATUS);
   assign fifo_pop = access && !pwrite && pop_pend;
   assign tick     = (tick_cnt == divisor);
   assign sample   = tick && (os_cnt == urx_pkg::OS_LAST);
   assign last_idx = 3'h4 + {1'b0, lcr[urx_pkg::LCR_WLEN_LSB+:2]};
   assign par_exp  = lcr[urx_pkg::LCR_STICK] ? !lcr[urx_pkg::LCR_EVEN]
                   : (lcr[urx_pkg::LCR_EVEN] ? ^shift : !(^shift));
   // Receive state machine
   always_comb
   begin
      next_state    = state;
      next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
      next_os_cnt   = tick ? os_cnt + 4'h1 : os_cnt;
      next_bit_idx  = bit_idx;
      next_shift    = shift;
      next_par_bit  = par_bit;
      next_all_low  = all_low;
      rx_push       = 1'b0;
      rx_entry      = '0;
      unique case (state)
         urx_pkg::URX_IDLE:
         begin
            next_os_cnt   = 4'h0;
            next_tick_cnt = 16'h0000;
            if (!rx_s)
            begin
               next_state = urx_pkg::URX_START;
            end
         end
         urx_pkg::URX_START:
         begin
            if (tick && os_cnt == urx_pkg::OS_HALF)
            begin
               // A glitch shorter than half a bit is not a start bit
               next_state   = rx_s ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
               next_os_cnt  = 4'h0;
               next_bit_idx = 3'h0;
               next_shift   = 8'h00;
               next_all_low = 1'b1;
            end
         end
         urx_pkg::URX_DATA:
         begin
            if (sample)
            begin
               next_shift[bit_idx] = rx_s;
               next_all_low        = all_low && !rx_s;
               next_bit_idx        = bit_idx + 3'h1;
               if (bit_idx == last_idx)
               begin
                  next_state = lcr[urx_pkg::LCR_PAR_EN] ? urx_pkg::URX_PARITY : urx_pkg::URX_STOP;
               end
            end
         end
         urx_pkg::URX_PARITY:
         begin
            if (sample)
            begin
               next_par_bit = rx_s;
               next_all_low = all_low && !rx_s;
               next_state   = urx_pkg::URX_STOP;
            end
         end
         urx_pkg::URX_STOP:
         begin
            if (sample)
            begin
               rx_push = 1'b1;
               if (!rx_s && all_low)
               begin
                  // Break: one zero character only, then hold off
                  rx_entry   = {1'b1, 2'b00, 8'h00};
                  next_state = urx_pkg::URX_BRK_WAIT;
               end
               else
               begin
                  // Flags ride in the entry with their character
                  rx_entry[EW-2] = lcr[urx_pkg::LCR_PAR_EN] && (par_bit != par_exp);
                  rx_entry[EW-3] = !rx_s;
                  rx_entry[7:0]  = shift;
                  next_state     = urx_pkg::URX_IDLE;
               end
            end
         end
         urx_pkg::URX_BRK_WAIT:
         begin
            if (rx_s)
            begin
               next_state = urx_pkg::URX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         state    <= urx_pkg::URX_IDLE;
         tick_cnt <= 16'h0000;
         os_cnt   <= 4'h0;
         bit_idx  <= 3'h0;
         shift    <= 8'h00;
         par_bit  <= 1'b0;
         all_low  <= 1'b0;
      end
      else if (clk_en)
      begin
         state    <= next_state;
         tick_cnt <= next_tick_cnt;
         os_cnt   <= next_os_cnt;
         bit_idx  <= next_bit_idx;
         shift    <= next_shift;
         par_bit  <= next_par_bit;
         all_low  <= next_all_low;
      end
   end

   // Registers, flags and bus answer
   always_comb
   begin
      next_lcr      = lcr;
      next_divisor  = divisor;
      next_flags    = flags;
      next_prdata   = prdata;
      next_pslverr  = pslverr;
      next_pop_pend = pop_pend;
      if (access && pwrite && paddr == urx_pkg::ADDR_LINE_CTRL)
      begin
         next_lcr = pwdata[7:0];
      end
      if (access && pwrite && paddr == urx_pkg::ADDR_DIVISOR)
      begin
         next_divisor = pwdata[15:0];
      end
      if (clear_wr)
      begin
         next_flags = urx_pkg::FLAGS_RESET;
      end
      // Sets are applied after the clear so a coincident event survives
      if (rx_push && fifo_full)
      begin
         next_flags[urx_pkg::STAT_OVERRUN] = 1'b1;
      end
      if (fifo_pop)
      begin
         next_flags[urx_pkg::STAT_BREAK]   = next_flags[urx_pkg::STAT_BREAK] | fifo_head[EW-1];
         next_flags[urx_pkg::STAT_PARITY]  = next_flags[urx_pkg::STAT_PARITY] | fifo_head[EW-2];
         next_flags[urx_pkg::STAT_FRAMING] = next_flags[urx_pkg::STAT_FRAMING] | fifo_head[EW-3];
      end
      if (setup)
      begin
         next_prdata   = 32'h0000_0000;
         next_pslverr  = 1'b0;
         next_pop_pend = 1'b0;
         unique case (paddr)
            urx_pkg::ADDR_DATA:
            begin
               next_pop_pend = !pwrite && !fifo_empty;
               if (!fifo_empty)
               begin
                  next_prdata[EW:0] = {flags[urx_pkg::STAT_OVERRUN], fifo_head};
               end
            end
            urx_pkg::ADDR_STATUS:
            begin
               next_prdata[3:0] = flags;
            end
            urx_pkg::ADDR_DIVISOR:
            begin
               next_prdata[15:0] = divisor;
            end
            urx_pkg::ADDR_LINE_CTRL:
            begin
               next_prdata[7:0] = lcr;
            end
            default:
            begin
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         lcr      <= urx_pkg::LCR_RESET;
         divisor  <= urx_pkg::DIV_RESET;
         flags    <= urx_pkg::FLAGS_RESET;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
         pop_pend <= 1'b0;
      end
      else if (clk_en)
      begin
         lcr      <= next_lcr;
         divisor  <= next_divisor;
         flags    <= next_flags;
         prdata   <= next_prdata;
         pslverr  <= next_pslverr;
         pop_pend <= next_pop_pend;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_overrun_set: assert property (clk_en && rx_push && fifo_full |=> flags[3])
      else $error("overrun not flagged");
   a_fifo_kept: assert property (clk_en && rx_push && fifo_full && !fifo_pop |=> fifo_full && $stable(fifo_head))
      else $error("full fifo changed on overrun");
   a_break_detect: assert property (clk_en && state == urx_pkg::URX_STOP && sample && !rx_s && all_low |-> rx_push && rx_entry == 11'h400)
      else $error("break not pushed as zero");
   a_break_hold: assert property (clk_en && rx_push && rx_entry[10] |=> state == urx_pkg::URX_BRK_WAIT ##1 (!rx_push) [*2])
      else $error("break pushed more than once");
   a_break_wait: assert property (clk_en && state == urx_pkg::URX_BRK_WAIT && !rx_s |=> state == urx_pkg::URX_BRK_WAIT)
      else $error("left break wait on low line");
   a_parity_off: assert property (rx_push && !lcr[1] |-> !rx_entry[9])
      else $error("parity error with parity off");
   a_frame_err: assert property (clk_en && state == urx_pkg::URX_STOP && sample && !rx_s && !all_low |-> rx_push && rx_entry[8])
      else $error("framing error missed");
   a_clear_all: assert property (clk_en && clear_wr && !rx_push |=> flags == 4'h0)
      else $error("clear write left a flag set");
   a_status_rsvd: assert property (clk_en && setup && !pwrite && paddr == 12'h004 |=> prdata[31:4] == 28'h0 && prdata[3:0] == $past(flags))
      else $error("status read wrong");
   a_pop_status: assert property (clk_en && fifo_pop && fifo_head[10] |=> flags[2])
      else $error("break of read entry not shown");
   a_read_quiet: assert property (clk_en && access && !pwrite && paddr == 12'h004 && !rx_push |=> flags == $past(flags))
      else $error("status read changed flags");
   a_reset_clear: assert property (@(posedge core_clk) disable iff (1'b0) !reset_n |=> flags == 4'h0)
      else $error("reset left a flag set");
endmodule

// ===== hdl/urx_fifo.sv
// Purpose: Receive FIFO holding each character with its own error flags.
// Assumes: DEPTH is a power of two.
// Notes:   With fifo_en low it behaves as a one-word holding register.
`timescale 1ns/1ps
module urx_fifo
#(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // Mode
   input  wire logic             fifo_en,
   // Fill side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   // Drain side
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic                  empty,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             do_push;
   logic             do_pop;

   assign empty = (count == '0);
   assign full  = fifo_en ? (count == (AW+1)'(DEPTH)) : !empty;
   assign head  = mem[rd_ptr];

   always_comb
   begin
      // A push into a full store is dropped so stored words stay intact
      do_push     = push && !full;
      do_pop      = pop && !empty;
      next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else if (clk_en)
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (clk_en && do_push)
      begin
         mem[wr_ptr] <= push_data;
      end
   end
endmodule

// ===== hdl/urx_pkg.sv
// Purpose: Shared constants and types for the receive error status block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Line control field layout is local to this block.
package urx_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_DATA      = 12'h000;
   localparam logic [11:0] ADDR_STATUS    = 12'h004;
   localparam logic [11:0] ADDR_DIVISOR   = 12'h024;
   localparam logic [11:0] ADDR_LINE_CTRL = 12'h02C;

   // Status field positions
   localparam int STAT_OVERRUN = 3;
   localparam int STAT_BREAK   = 2;
   localparam int STAT_PARITY  = 1;
   localparam int STAT_FRAMING = 0;
   localparam int DATA_FLAG_LSB = 8;

   // Line control field positions
   localparam int LCR_PAR_EN   = 1;
   localparam int LCR_EVEN     = 2;
   localparam int LCR_FIFO_EN  = 4;
   localparam int LCR_WLEN_LSB = 5;
   localparam int LCR_STICK    = 7;

   // Reset values
   localparam logic [7:0]  LCR_RESET   = 8'h00;
   localparam logic [15:0] DIV_RESET   = 16'h0000;
   localparam logic [3:0]  FLAGS_RESET = 4'h0;

   // Oversampling: last tick of a bit and the tick that marks mid start bit
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_HALF = 4'h7;

   typedef enum logic [2:0] {
      URX_IDLE,
      URX_START,
      URX_DATA,
      URX_PARITY,
      URX_STOP,
      URX_BRK_WAIT
   } urx_state_t;
endpackage

// ===== hdl/urx_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Input is asynchronous to core_clk.
// Notes:   Idle level of a serial line is high, so both stages reset high.
`timescale 1ns/1ps
module urx_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         stage1   <= '1;
         sync_out <= '1;
      end
      else if (clk_en)
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ===== verif/test_uart_rx_error_status_clear.sv
// Purpose: Self-checking bench for receive error status and error clear.
// Assumes: Divisor left at reset, so one bit is 16 core_clk cycles.
// Notes:   FIFO depth is cut to 4 so an overrun needs only five characters.
`timescale 1ns/1ps
module test_uart_rx_error_status_clear;
   localparam int          DEPTH     = 4;
   localparam logic [11:0] ADDR_NONE = 12'h010;
   localparam logic [11:0] DA        = urx_pkg::ADDR_DATA;
   localparam logic [11:0] ST        = urx_pkg::ADDR_STATUS;

   logic        core_clk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_pin;
   logic [31:0] rdat;
   logic        rerr;
   logic [7:0]  d;
   logic [7:0]  m;
   logic [7:0]  modes [4] = '{8'hF2, 8'hF6, 8'h72, 8'h76};
   int          fail_count;
   int          check_count;

   urx_core #(.FIFO_DEPTH(DEPTH)) dut
   (
      .core_clk(core_clk),
      .reset_n (reset_n),
      .clk_en  (1'b1),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .rx_pin  (rx_pin)
   );

   urx_line_model #(.BIT_CYC(16)) tx
   (
      .core_clk(core_clk),
      .rx_line (rx_pin)
   );

   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %08h, seen %08h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Setup, then access held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
         check("pready wait", 32'h0, 32'h1);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(what, rdat, exp);
   endtask

   // Stick mode forces the inverse of the even-select bit
   function automatic logic par_of(input logic [7:0] v, input logic [7:0] lcr);
      return lcr[urx_pkg::LCR_STICK] ? ~lcr[urx_pkg::LCR_EVEN] : (^v ^ ~lcr[urx_pkg::LCR_EVEN]);
   endfunction

   initial
   begin
      repeat (30000) @(posedge core_clk);
      fail_count++;
      $display("watchdog expired");
      give_verdict();
   end

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      reset_n = 1'b0;
      fail_count = 0;
      check_count = 0;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(ST, 32'h0, "status after reset");
      rd(ADDR_NONE, 32'h0, "unmapped read");
      check("unmapped error", {31'h0, rerr}, 32'h1);
      $display("test reset done");

      foreach (modes[i])
      begin
         m = modes[i];
         apb(1'b1, urx_pkg::ADDR_LINE_CTRL, {24'h0, m});
         d = 8'h3C + 8'(i);
         tx.send(d, par_of(d, m), 1'b1);
         tx.send(~d, ~par_of(~d, m), 1'b1);
         rd(DA, {24'h0, d}, "clean data");
         rd(ST, (i == 0) ? 32'h0 : 32'h2, "status before bad pop");
         rd(DA, 32'h200 | {24'h0, ~d}, "parity data");
      end
      rd(ST, 32'h2, "parity status");
      rd(ST, 32'h2, "status reread");
      $display("test parity done");

      tx.send(8'h55, par_of(8'h55, m), 1'b0);
      rd(ST, 32'h2, "status before framing pop");
      rd(DA, 32'h155, "framing data");
      rd(ST, 32'h3, "framing status");
      $display("test framing done");

      tx.hold_low(600);
      tx.send(8'h5A, par_of(8'h5A, m), 1'b1);
      rd(DA, 32'h400, "break entry");
      rd(DA, 32'h05A, "char after break");
      rd(ST, 32'h7, "break status");
      $display("test break done");

      for (int k = 0; k <= DEPTH; k++)
      begin
         d = 8'h11 + 8'(k);
         tx.send(d, par_of(d, m), 1'b1);
      end
      rd(ST, 32'hF, "status at overrun");
      apb(1'b1, ST, 32'hFFFF_FFFF);
      rd(ST, 32'h0, "status after clear");
      for (int k = 0; k < DEPTH; k++)
         rd(DA, {24'h0, 8'h11 + 8'(k)}, "kept data");
      rd(DA, 32'h0, "dropped word");
      tx.send(8'h16, par_of(8'h16, m), 1'b1);
      rd(DA, 32'h016, "data after drain");
      $display("test overrun done");

      tx.send(8'h33, par_of(8'h33, m), 1'b0);
      rd(DA, 32'h133, "framing again");
      apb(1'b1, ST, 32'h0);
      rd(ST, 32'h0, "status after zero clear");
      tx.send(8'h34, par_of(8'h34, m), 1'b0);
      rd(DA, 32'h134, "framing before reset");
      // Holding register mode, seven bits, no parity: second word overruns
      apb(1'b1, urx_pkg::ADDR_LINE_CTRL, 32'h0000_0040);
      tx.send_raw(8'h25, 7, 1'b1);
      tx.send_raw(8'h26, 7, 1'b1);
      rd(ST, 32'h9, "holding overrun status");
      rd(DA, 32'h825, "holding word kept");
      rd(DA, 32'h0, "holding word dropped");
      $display("test holding register done");
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(ST, 32'h0, "status after second reset");
      $display("test clear and reset done");
      give_verdict();
   end
endmodule

// ===== verif/urx_line_model.sv
// Purpose: Remote serial transmitter driving the receive pin.
// Assumes: One bit lasts BIT_CYC core_clk cycles; idle level is high.
// Notes:   Caller picks parity and stop levels, so errors are injected on purpose.
`timescale 1ns/1ps
module urx_line_model
#(
   parameter int BIT_CYC = 16
)
(
   // Clock
   input  wire logic core_clk,
   // Serial line
   output logic      rx_line
);
   initial rx_line = 1'b1;

   task automatic bit_out(input logic b, input int n);
      rx_line <= b;
      repeat (n) @(posedge core_clk);
   endtask

   // Start, eight data bits LSB first, parity, stop
   task automatic send(input logic [7:0] d, input logic par, input logic stop);
      bit_out(1'b0, BIT_CYC);
      for (int i = 0; i < 8; i++)
         bit_out(d[i], BIT_CYC);
      bit_out(par, BIT_CYC);
      bit_out(stop, BIT_CYC);
      // Idle gap lets the receiver settle after a low stop bit
      bit_out(1'b1, 2 * BIT_CYC);
   endtask

   task automatic hold_low(input int n);
      bit_out(1'b0, n);
      bit_out(1'b1, 2 * BIT_CYC);
   endtask

   // No parity bit: nbits data bits LSB first, then stop
   task automatic send_raw(input logic [7:0] d, input int nbits, input logic stop);
      bit_out(1'b0, BIT_CYC);
      for (int i = 0; i < nbits; i++)
         bit_out(d[i], BIT_CYC);
      bit_out(stop, BIT_CYC);
      bit_out(1'b1, 2 * BIT_CYC);
   endtask
endmodule
